// ==== src/fwpc_defs.svh ====
/*
 * Constants for the flash write-protect / reset controller (host side).
 * Assumes a 40 MHz sys_clk and a parallel flash with the usual strobes.
 */
`ifndef FWPC_DEFS_SVH
`define FWPC_DEFS_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses, AXI4-Lite)
// ----------------------------------------------------------------------
`define FWPC_REG_CTRL    8'h00
`define FWPC_REG_CMD     8'h04
`define FWPC_REG_STATUS  8'h08
`define FWPC_REG_RDATA   8'h0C
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define FWPC_CTRL_RST_BIT  0
`define FWPC_CTRL_WP_BIT   1
`define FWPC_CTRL_RESET    2'h1
// ----------------------------------------------------------------------
// Command register fields: [7:0] data, [8] read, [9] two-step
// [17:10] confirm data
// ----------------------------------------------------------------------
`define FWPC_CMD_RD_BIT    8
`define FWPC_CMD_TWO_BIT   9
// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define FWPC_ST_BUSY_BIT   0
`define FWPC_ST_RDY_BIT    1
`define FWPC_ST_REFUSE_BIT 2
// ----------------------------------------------------------------------
// Flash command codes and timing
// ----------------------------------------------------------------------
`define FWPC_CMD_READ_ARRAY 8'hFF
`define FWPC_CMD_CLR_STATUS 8'h50
`define FWPC_STROBE_NS      100
`define FWPC_CLK_NS         25
`define FWPC_STROBE_CYC     ((`FWPC_STROBE_NS + `FWPC_CLK_NS - 1) / `FWPC_CLK_NS)
`endif

// ==== src/fwpc_pkg.sv ====
/*
 * Types for the flash write-protect / reset controller.
 * Assumes fwpc_defs.svh supplies all numeric constants.
 */
package fwpc_pkg;
    typedef enum logic [2:0] {
        FWPC_IDLE  = 3'b000,
        FWPC_SETUP = 3'b001,
        FWPC_GAP   = 3'b010,
        FWPC_CONF  = 3'b011,
        FWPC_READ  = 3'b100,
        FWPC_DONE  = 3'b101
    } fwpc_state_t;
endpackage

// ==== src/fwpc_strobe.sv ====
/*
 * One bus cycle on the flash pins: chip select and write or output strobe
 * held low for a fixed count, data captured at the end.
 * Assumes flash data input already synchronised by the caller.
 */
`include "fwpc_defs.svh"
module fwpc_strobe
    import fwpc_pkg::*;
#(
    parameter int unsigned HOLD = `FWPC_STROBE_CYC
) (
    input  wire logic        sys_clk,  // System clock
    input  wire logic        nrst,     // Sync reset, active low
    input  wire logic        start,    // Begin one cycle
    input  wire logic        is_read,  // Read rather than write
    output logic             busy,     // Cycle in progress
    output logic             done,     // One-cycle end pulse
    output logic             ce_n_q,   // Chip select
    output logic             we_n_q,   // Write strobe
    output logic             oe_n_q    // Output strobe
);
    logic [7:0] cnt_q;

    // ------------------------------------------------------------------
    // Strobe timer
    // ------------------------------------------------------------------
    // Write strobe low only with chip select low so a write is seen by the flash
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_q  <= 8'h00;
            busy   <= 1'b0;
            done   <= 1'b0;
            ce_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy   <= 1'b1;
                cnt_q  <= 8'(HOLD);
                ce_n_q <= 1'b0;
                we_n_q <= is_read;
                oe_n_q <= !is_read;
            end else if (busy) begin
                if (cnt_q == 8'h01) begin
                    busy   <= 1'b0;
                    done   <= 1'b1;
                    ce_n_q <= 1'b1;
                    we_n_q <= 1'b1;
                    oe_n_q <= 1'b1;
                end
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    a_write_strobe: assert property (@(posedge sys_clk)
        disable iff (!nrst) !we_n_q |-> !ce_n_q)
        else $error("write strobe without chip select");
endmodule

// ==== src/fwpc_top.sv ====
/*
 * Host-side controller for a parallel flash: issues command writes,
 * two-step sequences and reads; drives reset/power-down and boot protect.
 * Assumes AXI4-Lite software access and flash pins outside sys_clk domain.
 */
// Flash usage rules for the host
// - Only issue operations with supplies valid and reset high.
// - Host reissues a whole command sequence after an abort.
// - Writes only with write strobe and chip select both low.
// - Host holds reset low over power transitions; writes disabled. The reset pin follows CTRL bit 0 only; supply_ok does not drive it.
`include "fwpc_defs.svh"
module fwpc_top
    import fwpc_pkg::*;
(
    input  wire logic        sys_clk,           // System clock 40 MHz
    input  wire logic        nrst,              // Sync reset, active low
    input  wire logic [7:0]  s_axi_awaddr,      // Write address
    input  wire logic        s_axi_awvalid,     // Write address valid
    output logic             s_axi_awready,     // Write address ready
    input  wire logic [31:0] s_axi_wdata,       // Write data
    input  wire logic [3:0]  s_axi_wstrb,       // Write byte enables
    input  wire logic        s_axi_wvalid,      // Write data valid
    output logic             s_axi_wready,      // Write data ready
    output logic [1:0]       s_axi_bresp,       // Write response
    output logic             s_axi_bvalid,      // Write response valid
    input  wire logic        s_axi_bready,      // Write response ready
    input  wire logic [7:0]  s_axi_araddr,      // Read address
    input  wire logic        s_axi_arvalid,     // Read address valid
    output logic             s_axi_arready,     // Read address ready
    output logic [31:0]      s_axi_rdata,       // Read data
    output logic [1:0]       s_axi_rresp,       // Read response
    output logic             s_axi_rvalid,      // Read data valid
    input  wire logic        s_axi_rready,      // Read data ready
    input  wire logic        supply_ok,         // Supplies in valid range
    input  wire logic        ready_busy_n,      // Flash ready/busy pin
    input  wire logic [7:0]  flash_dq_i,        // Flash data in
    output logic [7:0]       flash_dq_o,        // Flash data out
    output logic             flash_dq_oe_n,     // Data enable, low drives
    output logic             flash_ce_n,        // Chip select
    output logic             flash_we_n,        // Write strobe
    output logic             flash_oe_n,        // Output strobe
    output logic             reset_powerdown_n, // Reset/power-down pin
    output logic             boot_protect_n     // Boot-block protect pin
);
    fwpc_state_t state_q;
    logic [1:0]  ctrl_q;
    logic [17:0] cmd_q;
    logic [7:0]  rdata_q;
    logic        refuse_q;
    logic [1:0]  rb_sync_q, ok_sync_q;
    logic [7:0]  dq_s1_q, dq_s2_q;
    logic        st_start, st_busy, st_done;
    logic        ce_n_w, we_n_w, oe_n_w;
    logic        aw_hold_q, w_hold_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic        w_be0_q;
    logic        wr_fire, cmd_go;

    function automatic logic [31:0] rd_mux(input logic [7:0] a,
        input logic [31:0] st, input logic [1:0] c, input logic [7:0] d);
        case (a)
            `FWPC_REG_CTRL:   rd_mux = {30'h0, c};
            `FWPC_REG_STATUS: rd_mux = st;
            `FWPC_REG_RDATA:  rd_mux = {24'h0, d};
            default:          rd_mux = 32'h0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        rb_sync_q <= {rb_sync_q[0], ready_busy_n};
        ok_sync_q <= {ok_sync_q[0], supply_ok};
        dq_s1_q   <= flash_dq_i;
        dq_s2_q   <= dq_s1_q;
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign cmd_go  = wr_fire && aw_addr_q == `FWPC_REG_CMD;

    // Address and data latched in either order, response after both
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0;
            w_be0_q       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready;
            s_axi_wready  <= !w_hold_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_be0_q  <= s_axi_wstrb[0]; // Strobe kept with its data
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q == `FWPC_REG_CTRL ||
                    aw_addr_q == `FWPC_REG_CMD) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register: reset/power-down and boot-protect levels
    // ------------------------------------------------------------------
    // reset pin released high, boot protect low
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl_q <= `FWPC_CTRL_RESET;
        end else if (wr_fire && aw_addr_q == `FWPC_REG_CTRL &&
                     w_be0_q) begin
            ctrl_q <= w_data_q[1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            reset_powerdown_n <= 1'b0;
            boot_protect_n    <= 1'b0;
        end else begin
            reset_powerdown_n <= ctrl_q[`FWPC_CTRL_RST_BIT];
            boot_protect_n    <= ctrl_q[`FWPC_CTRL_WP_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    // setup then confirm
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q  <= FWPC_IDLE;
            cmd_q    <= 18'h0;
            refuse_q <= 1'b0;
        end else begin
            unique case (state_q)
                FWPC_IDLE: begin
                    if (cmd_go) begin
                        if (!ok_sync_q[1] || !reset_powerdown_n ||
                            !rb_sync_q[1]) begin
                            refuse_q <= 1'b1;
                        end else begin
                            refuse_q <= 1'b0;
                            cmd_q    <= w_data_q[17:0];
                            state_q  <= w_data_q[`FWPC_CMD_RD_BIT] ?
                                        FWPC_READ : FWPC_SETUP;
                        end
                    end
                end
                FWPC_SETUP:
                    if (st_done) state_q <= cmd_q[`FWPC_CMD_TWO_BIT] ?
                                            FWPC_GAP : FWPC_DONE;
                FWPC_GAP: state_q <= FWPC_CONF;
                FWPC_CONF: if (st_done) state_q <= FWPC_DONE;
                FWPC_READ: if (st_done) state_q <= FWPC_DONE;
                FWPC_DONE: state_q <= FWPC_IDLE;
                default: state_q <= FWPC_IDLE;
            endcase
            if (!reset_powerdown_n && state_q != FWPC_IDLE) begin
                state_q  <= FWPC_IDLE;
                refuse_q <= 1'b1;
            end
        end
    end

    assign st_start = (state_q == FWPC_SETUP || state_q == FWPC_CONF ||
                       state_q == FWPC_READ) && !st_busy && !st_done;

    fwpc_strobe u_strobe (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .start   (st_start),
        .is_read (state_q == FWPC_READ),
        .busy    (st_busy),
        .done    (st_done),
        .ce_n_q  (ce_n_w),
        .we_n_q  (we_n_w),
        .oe_n_q  (oe_n_w)
    );

    // ------------------------------------------------------------------
    // Flash pins and captured read data
    // ------------------------------------------------------------------
    // write gating
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flash_ce_n    <= 1'b1;
            flash_we_n    <= 1'b1;
            flash_oe_n    <= 1'b1;
            flash_dq_o    <= 8'h00;
            flash_dq_oe_n <= 1'b1;
            rdata_q       <= 8'h00;
        end else begin
            flash_ce_n    <= ce_n_w;
            flash_we_n    <= we_n_w || !ctrl_q[`FWPC_CTRL_RST_BIT];
            flash_oe_n    <= oe_n_w;
            flash_dq_o    <= (state_q == FWPC_CONF) ? cmd_q[17:10]
                                                    : cmd_q[7:0];
            flash_dq_oe_n <= we_n_w;
            if (st_done && state_q == FWPC_READ) rdata_q <= dq_s2_q;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux(s_axi_araddr,
                    {29'h0, refuse_q, rb_sync_q[1], state_q != FWPC_IDLE},
                    ctrl_q, rdata_q);
                s_axi_rresp   <= (s_axi_araddr == `FWPC_REG_CMD ||
                    s_axi_araddr > `FWPC_REG_RDATA ||
                    s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    a_no_write_rst: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        !reset_powerdown_n && !$past(reset_powerdown_n) |-> ##1 flash_we_n)
        else $error("write strobe while reset low");
    a_refuse_cmd: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        cmd_go && state_q == FWPC_IDLE &&
        (!ok_sync_q[1] || !reset_powerdown_n) |=>
        refuse_q && state_q == FWPC_IDLE)
        else $error("command accepted without supply or reset high");
    sequence s_setup_done;
        state_q == FWPC_SETUP && st_done && cmd_q[`FWPC_CMD_TWO_BIT];
    endsequence
    a_two_step: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        s_setup_done and reset_powerdown_n |=> state_q == FWPC_GAP)
        else $error("confirm not issued after setup");
endmodule

// ==== test/fwpc_flash_model.sv ====
/*
 * Behavioural flash device at the host pins: command latch, two-step
 * operations, status flags, lock bits and reset mode.
 * Assumes host pins change on sys_clk and ready/busy has a pull-up.
 */
module fwpc_flash_model (
    input  wire logic       sys_clk,      // Bench clock
    input  wire logic       ce_n,         // Chip select
    input  wire logic       we_n,         // Write strobe
    input  wire logic       oe_n,         // Output strobe
    input  wire logic [7:0] dq_in,        // Data from host
    input  wire logic       rp_n,         // Reset/power-down
    input  wire logic       wp_n,         // Boot protect
    input  wire logic       supply_ok,    // Supplies valid
    output logic [7:0]      dq_out,       // Data to host
    output logic            ready_busy_n, // Pulled-up busy pin
    output int              n_ops,        // Operations started
    output logic            aborted_q     // Operation cut by reset
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sr_q = 8'h00, setup_q = 8'h00, dq_q, last_q = 8'h00;
    logic       stat_q = 1'b0, we_q = 1'b1, ce_q = 1'b1;
    logic       lock_q = 1'b0, perm_q = 1'b0;
    int         cnt_q = 0;
    wire        rdy = (cnt_q == 0);

    initial begin
        n_ops = 0;
        aborted_q = 1'b0;
    end
    // busy pin low only while the engine runs
    assign ready_busy_n = rdy;
    // no output in reset; a released bus keeps moving
    assign dq_out = (!ce_n && !oe_n && rp_n)
                  ? (stat_q ? {rdy, sr_q[6:0]} : 8'hA5) : ~last_q;

    // Command latch, engine and status flags
    always @(posedge sys_clk) begin
        we_q <= we_n;
        ce_q <= ce_n;
        last_q <= dq_out;
        if (!we_n) dq_q <= dq_in;
        if (cnt_q > 0) cnt_q <= cnt_q - 1;
        if (!rp_n) begin
            // reset mode clears latch and flags
            sr_q <= 8'h00;
            stat_q <= 1'b0;
            setup_q <= 8'h00;
            // busy pin held while the cut run winds down
            if (cnt_q > 0) aborted_q <= 1'b1;
        end else begin
            if (cnt_q > 0 && !supply_ok) sr_q <= sr_q | 8'h18;
            // latch on strobe rise with select low
            if (we_n && !we_q && !ce_q) begin
                if (setup_q != 8'h00) begin
                    setup_q <= 8'h00;
                    if (!supply_ok) sr_q <= sr_q | 8'h18;
                    else if (setup_q == 8'h60 && perm_q)
                        sr_q <= sr_q | 8'h12;
                    else if (setup_q == 8'h40 && (lock_q || !wp_n))
                        sr_q <= sr_q | 8'h12;
                    // only the confirm write starts a run
                    else begin
                        cnt_q <= 40;
                        n_ops <= n_ops + 1;
                        lock_q <= lock_q | (setup_q == 8'h60);
                        perm_q <= perm_q |
                                  (setup_q == 8'h60 && dq_q == 8'hF1);
                    end
                end else begin
                    setup_q <= (dq_q == 8'h40 || dq_q == 8'h60) ? dq_q : 8'h00;
                    stat_q <= (dq_q != 8'hFF);
                    if (dq_q == 8'h50) sr_q <= 8'h00;
                end
            end
        end
    end
endmodule

// ==== test/fwpc_top_tb.sv ====
/*
 * Bench for fwpc_top: AXI4-Lite tasks run command sequences against
 * the flash model and compare status and data with expected values.
 * Assumes the design sources and fwpc_flash_model compiled first.
 */
`include "fwpc_defs.svh"
module fwpc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, nrst = 1'b0, supply_ok = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, aborted;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        ready_busy_n, flash_dq_oe_n, flash_ce_n, flash_we_n;
    logic        flash_oe_n, reset_powerdown_n, boot_protect_n;
    logic [7:0]  flash_dq_i, flash_dq_o;
    int          n_ops, mismatches = 0, n_checks = 0;

    fwpc_top dut_u (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_ok,
        .ready_busy_n, .flash_dq_i, .flash_dq_o, .flash_dq_oe_n,
        .flash_ce_n, .flash_we_n, .flash_oe_n, .reset_powerdown_n,
        .boot_protect_n);
    fwpc_flash_model mdl_u (.sys_clk, .ce_n(flash_ce_n),
        .we_n(flash_we_n), .oe_n(flash_oe_n), .dq_in(flash_dq_o),
        .rp_n(reset_powerdown_n), .wp_n(boot_protect_n), .supply_ok,
        .dq_out(flash_dq_i), .ready_busy_n, .n_ops, .aborted_q(aborted));

    // Bench clock, 40 MHz
    initial forever #12.5 sys_clk = ~sys_clk;

    // Verdict and end of run
    task automatic end_sim();
        $display("Counts: %0d checks, %0d mismatches", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tmo();
        mismatches++;
        $display("MISMATCH handshake expected answer seen none");
        end_sim();
    endtask
    // AXI write: address and data offered together, wait for response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        if (n == 100) tmo();
        rs = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        if (n == 100) tmo();
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    // Poll one status bit until it reaches a value
    task automatic poll(input int b, input logic v);
        int n;
        for (n = 0; n < 100; n++) begin
            axi_rd(`FWPC_REG_STATUS);
            if (rd[b] === v) break;
        end
        if (n == 100) tmo();
    endtask
    task automatic cmd(input logic [31:0] v);
        axi_wr(`FWPC_REG_CMD, v);
        poll(`FWPC_ST_BUSY_BIT, 1'h0);
    endtask
    function automatic logic [31:0] two(input logic [7:0] s, c);
        return {14'h0, c, 1'h1, 1'h0, s};
    endfunction
    task automatic flash_rd(input string nm, input logic [7:0] e);
        cmd(32'h1 << `FWPC_CMD_RD_BIT);
        axi_rd(`FWPC_REG_RDATA);
        chk(nm, rd, {24'h0, e});
    endtask
    task automatic sr_rd(input string nm, input logic [7:0] e);
        cmd(32'h70);
        flash_rd(nm, e);
    endtask
    task automatic prog();
        cmd(two(8'h40, 8'h5A));
        poll(`FWPC_ST_RDY_BIT, 1'h1);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        chk("pins_rst", {reset_powerdown_n, boot_protect_n, flash_ce_n,
            flash_we_n, flash_oe_n, flash_dq_oe_n}, 32'h0F);
        nrst <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk("rpd_up", reset_powerdown_n, 32'h1);
        axi_rd(`FWPC_REG_CTRL);
        chk("ctrl_rst", rd, `FWPC_CTRL_RESET);
        axi_rd(`FWPC_REG_STATUS);
        chk("st_rst", rd[2:0], 32'h2);
        axi_rd(8'h10);
        chk("rresp_unmap", rs, 32'h2);
        chk("rdata_unmap", rd, 32'h0);
        axi_rd(`FWPC_REG_CMD);
        chk("rresp_cmd", rs, 32'h2);
        axi_wr(8'h10, 32'h0);
        chk("bresp_unmap", rs, 32'h2);
        flash_rd("array_rd", 8'hA5);
        sr_rd("sr_idle", 8'h80);
        $display("test reset and map done");
        axi_wr(`FWPC_REG_CTRL, 32'h3);
        repeat (2) @(posedge sys_clk);
        chk("wp_pin", boot_protect_n, 32'h1);
        cmd(two(8'h40, 8'h5A));
        axi_rd(`FWPC_REG_STATUS);
        chk("rb_busy", rd[`FWPC_ST_RDY_BIT], 32'h0);
        chk("ops_prog", n_ops, 32'h1);
        poll(`FWPC_ST_RDY_BIT, 1'h1);
        sr_rd("sr_prog", 8'h80);
        axi_wr(`FWPC_REG_CTRL, 32'h1);
        cmd(two(8'h40, 8'h5A));
        sr_rd("sr_boot", 8'h92);
        chk("ops_boot", n_ops, 32'h1);
        cmd(32'h50);
        sr_rd("sr_clr", 8'h80);
        $display("test program and boot protect done");
        supply_ok <= 1'h0;
        repeat (4) @(posedge sys_clk);
        axi_wr(`FWPC_REG_CMD, 32'h70);
        axi_rd(`FWPC_REG_STATUS);
        chk("refused", rd[`FWPC_ST_REFUSE_BIT], 32'h1);
        supply_ok <= 1'h1;
        repeat (4) @(posedge sys_clk);
        cmd(32'h70);
        axi_rd(`FWPC_REG_STATUS);
        chk("refuse_clr", rd[`FWPC_ST_REFUSE_BIT], 32'h0);
        axi_wr(`FWPC_REG_CTRL, 32'h3);
        cmd(two(8'h40, 8'h5A));
        supply_ok <= 1'h0;
        repeat (4) @(posedge sys_clk);
        supply_ok <= 1'h1;
        poll(`FWPC_ST_RDY_BIT, 1'h1);
        sr_rd("sr_vfault", 8'h98);
        prog();
        sr_rd("sr_sticky", 8'h98);
        $display("test supply done");
        s_axi_wstrb <= 4'h0;
        axi_wr(`FWPC_REG_CTRL, 32'h2);
        s_axi_wstrb <= 4'hF;
        axi_rd(`FWPC_REG_CTRL);
        chk("ctrl_strb", rd, 32'h3);
        axi_wr(`FWPC_REG_CTRL, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk("rpd_low", reset_powerdown_n, 32'h0);
        axi_wr(`FWPC_REG_CMD, 32'h70);
        axi_rd(`FWPC_REG_STATUS);
        chk("rst_refused", rd[`FWPC_ST_REFUSE_BIT], 32'h1);
        axi_wr(`FWPC_REG_CTRL, 32'h3);
        repeat (4) @(posedge sys_clk);
        flash_rd("array_exit", 8'hA5);
        sr_rd("sr_reset", 8'h80);
        cmd(two(8'h40, 8'h5A));
        axi_wr(`FWPC_REG_CTRL, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk("rb_held", ready_busy_n, 32'h0);
        repeat (50) @(posedge sys_clk);
        chk("aborted", aborted, 32'h1);
        axi_wr(`FWPC_REG_CTRL, 32'h3);
        repeat (4) @(posedge sys_clk);
        prog();
        chk("ops_redo", n_ops, 32'h5);
        $display("test reset and abort done");
        cmd(two(8'h60, 8'h01));
        poll(`FWPC_ST_RDY_BIT, 1'h1);
        cmd(two(8'h40, 8'h5A));
        sr_rd("sr_locked", 8'h92);
        cmd(32'h50);
        cmd(two(8'h60, 8'hF1));
        poll(`FWPC_ST_RDY_BIT, 1'h1);
        cmd(two(8'h60, 8'h01));
        sr_rd("sr_perm", 8'h92);
        chk("ops_perm", n_ops, 32'h7);
        $display("test lock done");
        end_sim();
    end
endmodule
